// ---- src/cmac_cfg.svh ----
/*
  Constants of the CPU mode and addressing core: state counts of the
  arithmetic operations, address space masks, table limits and reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef CMAC_CFG_SVH
`define CMAC_CFG_SVH

// ============================================================
// State counts, one state is one clk_sys cycle
`define CMAC_ST_ADD 5'h01
`define CMAC_ST_MULU_B 5'h0C
`define CMAC_ST_MULS_B 5'h0D
`define CMAC_ST_DIVU_B 5'h0C
`define CMAC_ST_MULU_W 5'h14
`define CMAC_ST_MULS_W 5'h15
`define CMAC_ST_DIVU_W 5'h14

// ============================================================
// Address spaces and tables
`define CMAC_NORMAL_MASK 32'h0000FFFF
`define CMAC_ADV_MASK 32'h00FFFFFF
`define CMAC_IND_MASK 32'h000000FF
`define CMAC_VEC_BASE 32'h00000000
`define CMAC_PC_RESET 24'h000000
`define CMAC_INSN_BYTES 32'h00000002

`endif

// ---- src/cmac_core.sv ----
/*
  CPU mode and addressing core: arithmetic timing, effective address forming,
  indirect branch and vector fetch, exception stacking, fetch and power-down.
  Assumes an internal bus slave that answers each request with one bus_ack
  pulse (read data valid with it) and never acks while bus_req is low.
*/
`timescale 1ns/1ns
`include "cmac_cfg.svh"

module cmac_core
  import cmac_pkg::*;
#(
  parameter bit NORMAL_MODE_AVAIL = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic mode_pin,
  input wire logic intr_mode0,
  input wire logic op_valid,
  input wire cmac_op_t op_code,
  input wire cmac_size_t op_size,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic [7:0] condition_flags_reg,
  input wire logic [7:0] extended_control_reg,
  input wire logic wake_req,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  output logic op_ready,
  output logic op_done,
  output logic [31:0] op_result,
  output logic [31:0] op_wb,
  output logic [23:0] pc,
  output logic mode_adv,
  output logic power_down,
  output logic bus_req,
  output logic bus_we,
  output logic bus_byte,
  output logic bus_long,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata
);

  // ============================================================
  // Helpers
  function automatic logic [31:0] space_mask(input logic adv, input logic [31:0] ea);
    space_mask = adv ? (ea & `CMAC_ADV_MASK) : (ea & `CMAC_NORMAL_MASK);
  endfunction

  function automatic logic [31:0] even_addr(input logic [31:0] a, input cmac_size_t sz);
    even_addr = (sz == CMAC_SZ_BYTE) ? a : {a[31:1], 1'b0};
  endfunction

  function automatic logic [31:0] size_data(input logic [31:0] d, input cmac_size_t sz);
    unique case (sz)
      CMAC_SZ_BYTE: size_data = {24'h000000, d[7:0]};
      CMAC_SZ_WORD: size_data = {16'h0000, d[15:0]};
      default: size_data = d;
    endcase
  endfunction

  // ============================================================
  // Reset release and mode strap
  logic rst_meta_reg;
  logic rst_n_reg;
  logic strap_done_reg;
  logic mode_adv_reg;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Pins must not change while running, so they are caught once after release
  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      strap_done_reg <= 1'b0;
      mode_adv_reg <= 1'b1;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      mode_adv_reg <= NORMAL_MODE_AVAIL ? mode_pin : 1'b1;
    end
  end

  // ============================================================
  // Decode
  cmac_state_t state_reg;
  cmac_step_t step_reg;
  cmac_size_t size_reg;
  logic [31:0] sp_reg;
  logic [7:0] vec_reg;
  logic [7:0] flags_reg;
  logic [7:0] extctl_reg;
  logic icm0_reg;
  logic md_done;
  logic [31:0] md_result;

  wire take = op_valid && op_ready;
  wire idle_take = (state_reg == CMAC_S_IDLE) && take;
  wire acked = (state_reg == CMAC_S_ACCESS) && bus_ack;
  wire adv = mode_adv_reg;
  assign mode_adv = mode_adv_reg;
  wire is_md = (op_code == CMAC_OP_MULU) || (op_code == CMAC_OP_MULS)
    || (op_code == CMAC_OP_DIVU);
  wire wide = (op_size != CMAC_SZ_BYTE);
  wire cmac_md_t md_kind = cmac_md_t'((op_code == CMAC_OP_MULU)
    ? (wide ? CMAC_MD_MULU_W : CMAC_MD_MULU_B)
    : (op_code == CMAC_OP_MULS) ? (wide ? CMAC_MD_MULS_W : CMAC_MD_MULS_B)
    : (wide ? CMAC_MD_DIVU_W : CMAC_MD_DIVU_B));
  wire [31:0] disp = (op_size == CMAC_SZ_WORD) ? {{16{op_b[15]}}, op_b[15:0]} : op_b;
  wire [31:0] step_n = (op_size == CMAC_SZ_BYTE) ? 32'h00000001
    : (op_size == CMAC_SZ_WORD) ? 32'h00000002 : 32'h00000004;
  // Full 32-bit update so a carry reaches the upper half
  wire [31:0] inc_val = op_a + step_n;
  wire [31:0] dec_val = op_a - step_n;
  wire [31:0] pc_ext = {8'h00, pc};
  wire [31:0] sp_pc = sp_reg - (adv ? 32'h00000004 : 32'h00000002);
  wire [31:0] sp_w = sp_reg - 32'h00000002;
  wire [31:0] vec_off = adv ? {22'h000000, vec_reg, 2'b00} : {23'h000000, vec_reg, 1'b0};

  // ============================================================
  // Bus access launch
  wire want_rd = idle_take && (op_code == CMAC_OP_READ);
  wire want_ind = idle_take && (op_code == CMAC_OP_IND_BRANCH);
  wire want_fetch = idle_take && (op_code == CMAC_OP_FETCH);
  wire want_ext = (state_reg == CMAC_S_EXC) && !icm0_reg;
  wire want_pc = ((state_reg == CMAC_S_EXC) && icm0_reg) || (acked && step_reg == CMAC_STP_EXTCTL);
  wire want_flags = acked && (step_reg == CMAC_STP_PC_NRM);
  wire want_vec = acked && ((step_reg == CMAC_STP_PC_ADV) || (step_reg == CMAC_STP_FLAGS));
  wire launch = want_rd || want_ind || want_fetch || want_ext || want_pc || want_flags || want_vec;
  wire launch_we = want_ext || want_pc || want_flags;
  wire launch_byte = want_rd && (op_size == CMAC_SZ_BYTE);
  wire launch_long = (want_rd && op_size == CMAC_SZ_LONG) || (adv && (want_ind || want_pc || want_vec));
  wire [31:0] launch_addr = want_rd ? even_addr(space_mask(adv, op_a), op_size)
    : want_ind ? even_addr(op_a & `CMAC_IND_MASK, CMAC_SZ_LONG)
    : want_fetch ? space_mask(adv, {pc_ext[31:1], 1'b0})
    : want_pc ? even_addr(space_mask(adv, sp_pc), CMAC_SZ_WORD)
    : want_vec ? space_mask(adv, `CMAC_VEC_BASE + vec_off)
    : even_addr(space_mask(adv, sp_w), CMAC_SZ_WORD);
  wire [31:0] launch_data = want_ext ? {16'h0000, extctl_reg, extctl_reg}
    : want_flags ? {16'h0000, flags_reg, flags_reg}
    : adv ? {flags_reg, pc} : {16'h0000, pc[15:0]};
  wire cmac_step_t launch_step = cmac_step_t'(want_rd ? CMAC_STP_READ
    : want_ind ? CMAC_STP_IND
    : want_fetch ? CMAC_STP_FETCH : want_ext ? CMAC_STP_EXTCTL
    : want_pc ? (adv ? CMAC_STP_PC_ADV : CMAC_STP_PC_NRM)
    : want_flags ? CMAC_STP_FLAGS : CMAC_STP_VEC);
  // Upper byte of a fetched branch address is reserved and forced to zero
  wire [23:0] branch_target = adv ? bus_rdata[23:0] : {8'h00, bus_rdata[15:0]};
  wire [31:0] pc_step = space_mask(adv, pc_ext + `CMAC_INSN_BYTES);

  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_byte <= 1'b0;
      bus_long <= 1'b0;
      bus_addr <= 32'h00000000;
      bus_wdata <= 32'h00000000;
    end
    else if (launch)
    begin
      bus_req <= 1'b1;
      bus_we <= launch_we;
      bus_byte <= launch_byte;
      bus_long <= launch_long;
      bus_addr <= launch_addr;
      bus_wdata <= launch_data;
    end
    else if (bus_ack)
      bus_req <= 1'b0;
  end

  cmac_muldiv u_muldiv (
    .clk_sys(clk_sys),
    .rst_n(rst_n_reg),
    .start(idle_take && is_md),
    .kind(md_kind),
    .opnd_a(op_a),
    .opnd_b(op_b),
    .done(md_done),
    .result(md_result)
  );

  // ============================================================
  // Sequencer
  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= CMAC_S_IDLE;
      step_reg <= CMAC_STP_READ;
      size_reg <= CMAC_SZ_BYTE;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_result <= 32'h00000000;
      op_wb <= 32'h00000000;
      pc <= `CMAC_PC_RESET;
      power_down <= 1'b0;
      sp_reg <= 32'h00000000;
      vec_reg <= 8'h00;
      flags_reg <= 8'h00;
      extctl_reg <= 8'h00;
      icm0_reg <= 1'b0;
    end
    else
    begin
      op_done <= 1'b0;
      if (launch)
        step_reg <= launch_step;
      if (launch && launch_we)
        sp_reg <= launch_addr;
      unique case (state_reg)
        CMAC_S_IDLE:
        begin
          op_ready <= strap_done_reg;
          if (take)
          begin
            size_reg <= op_size;
            unique case (op_code)
              CMAC_OP_ADD, CMAC_OP_SUB:
              begin
                op_result <= size_data((op_code == CMAC_OP_ADD) ? op_a + op_b : op_a - op_b,
                  op_size);
                op_done <= 1'b1;
              end
              CMAC_OP_MULU, CMAC_OP_MULS, CMAC_OP_DIVU:
              begin
                state_reg <= CMAC_S_MULDIV;
                op_ready <= 1'b0;
              end
              CMAC_OP_EA_DISP, CMAC_OP_EA_POSTINC, CMAC_OP_EA_PREDEC:
              begin
                op_result <= space_mask(adv, (op_code == CMAC_OP_EA_DISP) ? op_a + disp
                  : (op_code == CMAC_OP_EA_PREDEC) ? dec_val : op_a);
                op_wb <= (op_code == CMAC_OP_EA_PREDEC) ? dec_val
                  : (op_code == CMAC_OP_EA_POSTINC) ? inc_val : op_a;
                op_done <= 1'b1;
              end
              CMAC_OP_READ, CMAC_OP_IND_BRANCH, CMAC_OP_FETCH:
              begin
                op_result <= pc_ext;
                state_reg <= CMAC_S_ACCESS;
                op_ready <= 1'b0;
              end
              CMAC_OP_EXCEPT:
              begin
                vec_reg <= op_a[7:0];
                sp_reg <= op_b;
                flags_reg <= condition_flags_reg;
                extctl_reg <= extended_control_reg;
                icm0_reg <= intr_mode0;
                state_reg <= CMAC_S_EXC;
                op_ready <= 1'b0;
              end
              CMAC_OP_SLEEP:
              begin
                power_down <= 1'b1;
                state_reg <= CMAC_S_SLEEP;
                op_ready <= 1'b0;
              end
              default:
                op_done <= 1'b1;
            endcase
          end
        end
        CMAC_S_MULDIV:
        begin
          if (md_done)
          begin
            op_result <= md_result;
            op_done <= 1'b1;
            op_ready <= 1'b1;
            state_reg <= CMAC_S_IDLE;
          end
        end
        CMAC_S_EXC:
          state_reg <= CMAC_S_ACCESS;
        CMAC_S_ACCESS:
        begin
          if (bus_ack)
          begin
            unique case (step_reg)
              CMAC_STP_READ:
                op_result <= size_data(bus_rdata, size_reg);
              CMAC_STP_IND, CMAC_STP_VEC:
                pc <= branch_target;
              CMAC_STP_FETCH:
              begin
                op_result <= {16'h0000, bus_rdata[15:0]};
                pc <= pc_step[23:0];
              end
              default:
                op_wb <= sp_reg;
            endcase
            if (step_reg == CMAC_STP_VEC)
              op_result <= sp_reg;
            if (!launch)
            begin
              op_done <= 1'b1;
              op_ready <= 1'b1;
              state_reg <= CMAC_S_IDLE;
            end
          end
        end
        CMAC_S_SLEEP:
        begin
          if (wake_req)
          begin
            power_down <= 1'b0;
            op_ready <= 1'b1;
            state_reg <= CMAC_S_IDLE;
          end
        end
      endcase
    end
  end

  // ============================================================
  // Checks
  logic [4:0] age_reg;
  cmac_md_t md_last_reg;
  logic md_last_valid_reg;
  logic ea_last_reg;

  always_ff @(posedge clk_sys or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      age_reg <= 5'h00;
      md_last_reg <= CMAC_MD_MULU_B;
      md_last_valid_reg <= 1'b0;
      ea_last_reg <= 1'b0;
    end
    else
    begin
      // The take cycle counts as the first state
      age_reg <= take ? 5'h01 : (age_reg == 5'h1F) ? age_reg : age_reg + 5'h01;
      if (take)
      begin
        md_last_reg <= md_kind;
        md_last_valid_reg <= is_md;
        ea_last_reg <= (op_code == CMAC_OP_EA_DISP) || (op_code == CMAC_OP_EA_PREDEC)
          || (op_code == CMAC_OP_EA_POSTINC);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_reg);

  a_add_one_state: assert property (
    take && (op_code == CMAC_OP_ADD || op_code == CMAC_OP_SUB) |=> op_done)
    else $error("add or sub did not answer after one state");
  a_mul_byte_lat: assert property (
    op_done && md_last_valid_reg && (md_last_reg == CMAC_MD_MULU_B || md_last_reg == CMAC_MD_MULS_B)
    |-> age_reg == ((md_last_reg == CMAC_MD_MULU_B) ? `CMAC_ST_MULU_B : `CMAC_ST_MULS_B))
    else $error("byte multiply state count wrong");
  a_div_byte_lat: assert property (
    op_done && md_last_valid_reg && md_last_reg == CMAC_MD_DIVU_B |-> age_reg == `CMAC_ST_DIVU_B)
    else $error("byte divide state count wrong");
  a_mul_word_lat: assert property (
    op_done && md_last_valid_reg && (md_last_reg == CMAC_MD_MULU_W || md_last_reg == CMAC_MD_MULS_W)
    |-> age_reg == ((md_last_reg == CMAC_MD_MULU_W) ? `CMAC_ST_MULU_W : `CMAC_ST_MULS_W))
    else $error("word multiply state count wrong");
  a_div_word_lat: assert property (
    op_done && md_last_valid_reg && md_last_reg == CMAC_MD_DIVU_W |-> age_reg == `CMAC_ST_DIVU_W)
    else $error("word divide state count wrong");
  a_normal_ea_low: assert property (
    op_done && ea_last_reg && !mode_adv_reg |-> op_result[31:16] == 16'h0000)
    else $error("normal mode address above 16 bits");
  a_adv_only_mode: assert property (
    !NORMAL_MODE_AVAIL && strap_done_reg |-> mode_adv_reg)
    else $error("normal mode entered on advanced-only chip");
  a_ind_low_page: assert property (
    bus_req && step_reg == CMAC_STP_IND |-> bus_addr[31:8] == 24'h000000)
    else $error("indirect operand outside first 256 bytes");
  a_wide_even_addr: assert property (
    bus_req && !bus_byte |-> !bus_addr[0])
    else $error("wide access at odd address");
  a_vec_low_bits: assert property (
    acked && step_reg == CMAC_STP_VEC && mode_adv_reg |=> pc == $past(bus_rdata[23:0]))
    else $error("vector target not low 24 bits");
  a_extctl_skip: assert property (
    state_reg == CMAC_S_EXC |=> (step_reg == CMAC_STP_EXTCTL) == !icm0_reg)
    else $error("extended control push wrong for interrupt mode");
  a_sleep_entry: assert property (
    take && op_code == CMAC_OP_SLEEP |=> power_down && !op_ready)
    else $error("sleep did not enter power-down");

  c_signed_word_mul: cover property (take && op_code == CMAC_OP_MULS && op_size == CMAC_SZ_WORD);
  c_exc_full_frame: cover property (want_ext ##[1:20] want_vec);
  c_fetch_done: cover property (acked && step_reg == CMAC_STP_FETCH);
  c_sleep_wake: cover property (power_down ##[1:50] !power_down);

endmodule

// ---- src/cmac_muldiv.sv ----
/*
  Multiply and divide unit with fixed state counts per operation kind.
  Assumes start is a one-cycle pulse given only while the unit is idle.
*/
`timescale 1ns/1ns
`include "cmac_cfg.svh"

module cmac_muldiv
  import cmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire cmac_md_t kind,
  input wire logic [31:0] opnd_a,
  input wire logic [31:0] opnd_b,
  output logic done,
  output logic [31:0] result
);

  // ============================================================
  // Decode
  function automatic logic [4:0] states_of(input cmac_md_t k);
    unique case (k)
      CMAC_MD_MULU_B: states_of = `CMAC_ST_MULU_B;
      CMAC_MD_MULS_B: states_of = `CMAC_ST_MULS_B;
      CMAC_MD_DIVU_B: states_of = `CMAC_ST_DIVU_B;
      CMAC_MD_MULU_W: states_of = `CMAC_ST_MULU_W;
      CMAC_MD_MULS_W: states_of = `CMAC_ST_MULS_W;
      CMAC_MD_DIVU_W: states_of = `CMAC_ST_DIVU_W;
    endcase
  endfunction

  // Divide by zero leaves the dividend untouched
  function automatic logic [31:0] calc(input cmac_md_t k, input logic [31:0] a,
                                       input logic [31:0] b);
    logic [15:0] p16;
    logic signed [15:0] s16;
    logic signed [31:0] s32;
    logic [15:0] q16;
    logic [15:0] r16;
    logic [31:0] q32;
    logic [31:0] r32;
    p16 = {8'h00, a[7:0]} * {8'h00, b[7:0]};
    s16 = $signed({{8{a[7]}}, a[7:0]}) * $signed({{8{b[7]}}, b[7:0]});
    s32 = $signed({{16{a[15]}}, a[15:0]}) * $signed({{16{b[15]}}, b[15:0]});
    q16 = (b[7:0] == 8'h00) ? a[15:0] : a[15:0] / {8'h00, b[7:0]};
    r16 = (b[7:0] == 8'h00) ? a[15:0] : a[15:0] % {8'h00, b[7:0]};
    q32 = (b[15:0] == 16'h0000) ? a : a / {16'h0000, b[15:0]};
    r32 = (b[15:0] == 16'h0000) ? a : a % {16'h0000, b[15:0]};
    unique case (k)
      CMAC_MD_MULU_B: calc = {16'h0000, p16};
      CMAC_MD_MULS_B: calc = {16'h0000, s16};
      CMAC_MD_DIVU_B: calc = (b[7:0] == 8'h00) ? a : {16'h0000, r16[7:0], q16[7:0]};
      CMAC_MD_MULU_W: calc = {16'h0000, a[15:0]} * {16'h0000, b[15:0]};
      CMAC_MD_MULS_W: calc = s32;
      CMAC_MD_DIVU_W: calc = (b[15:0] == 16'h0000) ? a : {r32[15:0], q32[15:0]};
    endcase
  endfunction

  // ============================================================
  // Countdown: the take edge is the first state and done rises one cycle
  // before the core reports, so the answer stands in the last counted state
  logic [4:0] cnt_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 5'h00;
      done <= 1'b0;
      result <= 32'h00000000;
    end
    else
    begin
      done <= (cnt_reg == 5'h01);
      if (start)
      begin
        cnt_reg <= states_of(kind) - 5'h02;
        result <= calc(kind, opnd_a, opnd_b);
      end
      else if (cnt_reg != 5'h00)
        cnt_reg <= cnt_reg - 5'h01;
    end
  end

endmodule

// ---- src/cmac_pkg.sv ----
/*
  Types of the CPU mode and addressing core: operation codes, operand sizes,
  arithmetic kinds, sequencer states and bus steps.
  Assumes nothing of its surroundings.
*/
package cmac_pkg;

  // ============================================================
  // Operations accepted on the request port
  typedef enum logic [3:0] {
    CMAC_OP_ADD,
    CMAC_OP_SUB,
    CMAC_OP_MULU,
    CMAC_OP_MULS,
    CMAC_OP_DIVU,
    CMAC_OP_EA_DISP,
    CMAC_OP_EA_POSTINC,
    CMAC_OP_EA_PREDEC,
    CMAC_OP_READ,
    CMAC_OP_IND_BRANCH,
    CMAC_OP_FETCH,
    CMAC_OP_EXCEPT,
    CMAC_OP_SLEEP
  } cmac_op_t;

  typedef enum logic [1:0] {
    CMAC_SZ_BYTE,
    CMAC_SZ_WORD,
    CMAC_SZ_LONG
  } cmac_size_t;

  typedef enum logic [2:0] {
    CMAC_MD_MULU_B,
    CMAC_MD_MULS_B,
    CMAC_MD_DIVU_B,
    CMAC_MD_MULU_W,
    CMAC_MD_MULS_W,
    CMAC_MD_DIVU_W
  } cmac_md_t;

  typedef enum logic [2:0] {
    CMAC_S_IDLE,
    CMAC_S_MULDIV,
    CMAC_S_EXC,
    CMAC_S_ACCESS,
    CMAC_S_SLEEP
  } cmac_state_t;

  typedef enum logic [2:0] {
    CMAC_STP_READ,
    CMAC_STP_IND,
    CMAC_STP_FETCH,
    CMAC_STP_EXTCTL,
    CMAC_STP_PC_ADV,
    CMAC_STP_PC_NRM,
    CMAC_STP_FLAGS,
    CMAC_STP_VEC
  } cmac_step_t;

endpackage

// ---- tb/cmac_core_tb.sv ----
/* Self-checking bench of cmac_core against a bus memory model.
   Assumes the core is built advanced-only, with mode_pin held at 0. */
`timescale 1ns/1ns
module cmac_core_tb
  import cmac_pkg::*;
;
  // ============================================================
  // Signals
  logic clk_sys = 1'b0, resetn = 1'b0, mode_pin = 1'b0, intr_mode0 = 1'b0;
  logic op_valid = 1'b0, wake_req = 1'b0;
  cmac_op_t op_code = CMAC_OP_ADD;
  cmac_size_t op_size = CMAC_SZ_LONG;
  logic [31:0] op_a = 32'h0, op_b = 32'h0, rnd = 32'h4E, b, m;
  logic [7:0] condition_flags_reg = 8'h0, extended_control_reg = 8'h0, n_wr, w;
  logic op_ready, op_done, power_down, bus_req, bus_we, bus_byte, bus_long, bus_ack, mode_adv;
  logic [31:0] op_result, op_wb, bus_addr, bus_wdata, bus_rdata;
  logic [23:0] pc;
  int n_fail = 0, compares = 0, lat, k;
  cmac_op_t ops[7] = '{CMAC_OP_ADD, CMAC_OP_MULU, CMAC_OP_MULS, CMAC_OP_DIVU,
    CMAC_OP_MULU, CMAC_OP_MULS, CMAC_OP_DIVU};
  int lat_tab[7] = '{1, 12, 13, 12, 20, 21, 20};

  cmac_core i_cmac_core (.clk_sys, .resetn, .mode_pin, .intr_mode0, .op_valid, .op_code,
    .op_size, .op_a, .op_b, .condition_flags_reg, .extended_control_reg, .wake_req,
    .bus_ack, .bus_rdata, .op_ready, .op_done, .op_result, .op_wb, .pc, .mode_adv, .power_down,
    .bus_req, .bus_we, .bus_byte, .bus_long, .bus_addr, .bus_wdata);
  cmac_mem i_cmac_mem (.clk_sys, .bus_req, .bus_we, .bus_addr, .bus_ack, .bus_rdata, .n_wr);

  // ============================================================
  // Tasks
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Request held until taken; lat counts edges from the take to op_done
  task automatic op(input cmac_op_t c, input cmac_size_t s, input logic [31:0] a, bb);
    op_code = c;
    op_size = s;
    op_a = a;
    op_b = bb;
    op_valid = 1'b1;
    k = 0;
    do @(posedge clk_sys); while (op_ready !== 1'b1 && ++k < 50);
    #1 op_valid = 1'b0;
    lat = 0;
    do
    begin
      @(posedge clk_sys);
      lat++;
    end
    while (op_done !== 1'b1 && lat < 60);
    #1;
  endtask

  // ============================================================
  // Clock, bus watch, watchdog
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (bus_req && bus_ack)
    begin
      chk({bus_addr[31:24], 23'h0, bus_addr[0] & ~bus_byte}, 32'h0);
      if (bus_we)
        chk(bus_long ? bus_wdata[31:24] : bus_wdata[7:0],
          bus_long ? condition_flags_reg : extended_control_reg);
    end
  // Tests need about 300 cycles; the 5000-cycle limit, over fifteen times that, means a hang
  initial
  begin
    #250000;
    n_fail++;
    summarize();
  end

  // ============================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk(mode_adv, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      rnd = nx(rnd);
      b = {rnd[15:0], rnd[31:16]};
      op(ops[i], i == 0 ? CMAC_SZ_LONG : (i < 4 ? CMAC_SZ_BYTE : CMAC_SZ_WORD), rnd, b);
      chk(lat, lat_tab[i]);
      if (i == 0)
        chk(op_result, rnd + b);
      if (i == 1)
        chk(op_result, 32'(rnd[7:0]) * 32'(b[7:0]));
      if (i == 4)
        chk(op_result, 32'(rnd[15:0]) * 32'(b[15:0]));
      if (i == 5)
        chk(op_result, 32'($signed(rnd[15:0]) * $signed(b[15:0])));
    end
    op(CMAC_OP_SUB, CMAC_SZ_LONG, rnd, b);
    chk(lat, 1);
    chk(op_result, rnd - b);
    op(CMAC_OP_EA_POSTINC, CMAC_SZ_LONG, {rnd[31:16], 16'hFFFE}, 32'h0);
    chk(op_wb, {rnd[31:16] + 16'h0001, 16'h0002});
    chk(op_result, {8'h0, rnd[23:16], 16'hFFFE});
    op(CMAC_OP_EA_PREDEC, CMAC_SZ_WORD, {rnd[31:16], 16'h0000}, 32'h0);
    chk(op_wb, {rnd[31:16] - 16'h0001, 16'hFFFE});
    $display("test arithmetic done");
    for (int i = 0; i < 4; i++)
    begin
      rnd = nx(rnd);
      op(CMAC_OP_IND_BRANCH, CMAC_SZ_LONG, rnd, 32'h0);
      b = i_cmac_mem.rd({24'h0, rnd[7:1], 1'b0});
      chk(pc, b[23:0]);
      op(CMAC_OP_FETCH, CMAC_SZ_WORD, 32'h0, 32'h0);
      m = i_cmac_mem.rd({8'h0, b[23:1], 1'b0});
      chk(op_result, {16'h0, m[15:0]});
      chk(pc, b[23:0] + 24'h2);
      op(CMAC_OP_READ, CMAC_SZ_WORD, {8'h0, rnd[23:1], 1'b1}, 32'h0);
      m = i_cmac_mem.rd({8'h0, rnd[23:1], 1'b0});
      chk(op_result, {16'h0, m[15:0]});
      b = {rnd[7:0], rnd[31:8]};
      op(CMAC_OP_EA_DISP, i[0] ? CMAC_SZ_LONG : CMAC_SZ_WORD, rnd, b);
      m = i[0] ? b : {{16{b[15]}}, b[15:0]};
      chk(op_result, (rnd + m) & 32'h00FFFFFF);
    end
    $display("test branch fetch read done");
    for (int i = 0; i < 2; i++)
    begin
      rnd = nx(rnd);
      intr_mode0 = i[0];
      condition_flags_reg = rnd[7:0];
      extended_control_reg = rnd[15:8];
      w = n_wr;
      b = {8'h0, rnd[31:9], 1'b0};
      op(CMAC_OP_EXCEPT, CMAC_SZ_LONG, {26'h0, rnd[21:16]}, b);
      m = i_cmac_mem.rd({24'h0, rnd[21:16], 2'b00});
      chk(pc, m[23:0]);
      chk(op_result, b - (i ? 32'h4 : 32'h6));
      chk(n_wr - w, i ? 32'h1 : 32'h2);
    end
    $display("test exception done");
    op(CMAC_OP_SLEEP, CMAC_SZ_WORD, 32'h0, 32'h0);
    chk(power_down, 1'b1);
    wake_req = 1'b1;
    k = 0;
    do @(posedge clk_sys); while (power_down === 1'b1 && ++k < 10);
    #1 wake_req = 1'b0;
    chk(power_down, 1'b0);
    op(CMAC_OP_ADD, CMAC_SZ_BYTE, rnd, b);
    chk(lat, 1);
    $display("test sleep done");
    summarize();
  end
endmodule

// ---- tb/cmac_mem.sv ----
/* Bus memory model for the core bench.
   Assumes the core holds bus_req until one bus_ack pulse. */
`timescale 1ns/1ns
module cmac_mem
(
  input wire logic clk_sys,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  output logic bus_ack = 1'b0,
  output logic [31:0] bus_rdata = 32'h0,
  output logic [7:0] n_wr = 8'h0
);
  // ============================================================
  // Answers
  logic slow = 1'b0;
  logic [1:0] cnt = 2'h0;
  // Top byte is never zero for vector table addresses, so an unmasked vector shows up
  function automatic logic [31:0] rd(input logic [31:0] a);
    return {~a[15:0], a[15:0] ^ 16'h0001};
  endfunction
  // Data toggles outside the ack cycle so a late sample cannot pass
  always @(posedge clk_sys)
  begin
    bus_ack <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_req && !bus_ack)
    begin
      if (cnt == {slow, 1'b0})
      begin
        bus_ack <= 1'b1;
        bus_rdata <= rd(bus_addr);
        n_wr <= n_wr + {7'h0, bus_we};
        slow <= !slow;
        cnt <= 2'h0;
      end
      else
        cnt <= cnt + 2'h1;
    end
  end
endmodule
